// file: shared/abwr_map.svh
`ifndef ABWR_MAP_SVH
`define ABWR_MAP_SVH
`define ABWR_WIN_TOP 8'h5F
`define ABWR_ACC_HALF 8'h80
`define ABWR_SFR_BANK 4'hF
`endif

// file: shared/abwr_pkg.sv
package abwr_pkg;
	typedef enum logic [3:0] {
		ABWR_DIRECT_ACC = 4'h1,
		ABWR_DIRECT_BSR = 4'h2,
		ABWR_INDIRECT = 4'h4,
		ABWR_WINDOW = 4'h8
	} abwr_path_e;
endpackage

// file: logic/abwr_remap.sv
`timescale 1ns/1ps
`default_nettype none
`include "abwr_map.svh"
module abwr_remap
	import abwr_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic op_valid,
	input wire logic [7:0] op_literal,
	input wire logic op_access_bit,
	input wire logic op_indirect,
	input wire logic [ADDR_W-1:0] op_indirect_addr,
	input wire logic ext_set_en,
	input wire logic [3:0] bank_select_register,
	input wire logic [ADDR_W-1:0] third_indirect_pointer,
	output logic mem_valid,
	output logic [ADDR_W-1:0] mem_addr,
	output logic mem_windowed
);
	abwr_path_e path;
	logic [ADDR_W-1:0] nxt_addr;
	logic [ADDR_W-1:0] win_addr;
	logic [ADDR_W-1:0] acc_addr;
	logic mem_valid_ff;
	logic [ADDR_W-1:0] mem_addr_ff;
	logic mem_windowed_ff;

	// Sum drops its carry, so a pointer near the top folds to the bottom
	// window address formation
	assign win_addr = third_indirect_pointer + ADDR_W'(op_literal);
	// Normal Access map: low half in bank zero, upper half in the SFR bank
	assign acc_addr = (op_literal < `ABWR_ACC_HALF) ? ADDR_W'(op_literal) :
		ADDR_W'({`ABWR_SFR_BANK, op_literal});

	// Indirect beats banked, banked beats window, so the window never hides them
	// Path selection per operand
	always_comb begin
		if (op_indirect) begin
			path = ABWR_INDIRECT;
		end else if (op_access_bit) begin
			path = ABWR_DIRECT_BSR;
		end else if (ext_set_en && op_literal <= `ABWR_WIN_TOP) begin
			path = ABWR_WINDOW;
		end else begin
			// above 5Fh, or with the extended set off, the normal Access map
			path = ABWR_DIRECT_ACC;
		end
	end

	// Every path code is listed; the default only guards illegal codes
	// Address mux per path
	always_comb begin
		unique case (path)
			ABWR_INDIRECT: nxt_addr = op_indirect_addr;
			ABWR_DIRECT_BSR: nxt_addr = ADDR_W'({bank_select_register, op_literal});
			// window spans pointer to pointer plus 5Fh
			ABWR_WINDOW: nxt_addr = win_addr;
			ABWR_DIRECT_ACC: nxt_addr = acc_addr;
			default: nxt_addr = acc_addr;
		endcase
	end

	// Request strobe to data memory, one cycle per taken operand
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mem_valid_ff <= 1'h0;
		end else begin
			mem_valid_ff <= op_valid;
		end
	end

	// Effective address, held between requests
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mem_addr_ff <= '0;
		end else if (op_valid) begin
			mem_addr_ff <= nxt_addr;
		end
	end

	// Window flag, held with the address it describes
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mem_windowed_ff <= 1'h0;
		end else if (op_valid) begin
			mem_windowed_ff <= (path == ABWR_WINDOW);
		end
	end

	assign mem_valid = mem_valid_ff;
	assign mem_addr = mem_addr_ff;
	assign mem_windowed = mem_windowed_ff;

	window_addr_a: assert property (@(posedge mclk) disable iff (rst)
		op_valid && !op_indirect && !op_access_bit && ext_set_en && op_literal <= 8'h5F
		|=> mem_windowed && mem_addr == $past(third_indirect_pointer) + ADDR_W'($past(op_literal)))
		else $error("window address wrong");
	high_access_a: assert property (@(posedge mclk) disable iff (rst)
		op_valid && !op_indirect && !op_access_bit && op_literal >= 8'h80
		|=> !mem_windowed && mem_addr == ADDR_W'({4'hF, $past(op_literal)}))
		else $error("high access map wrong");
	// gap literals stay in bank zero
	gap_access_a: assert property (@(posedge mclk) disable iff (rst)
		op_valid && !op_indirect && !op_access_bit && op_literal > 8'h5F && op_literal < 8'h80
		|=> !mem_windowed && mem_addr == ADDR_W'($past(op_literal)))
		else $error("gap access map wrong");
	banked_path_a: assert property (@(posedge mclk) disable iff (rst)
		op_valid && !op_indirect && op_access_bit
		|=> !mem_windowed && mem_addr == ADDR_W'({$past(bank_select_register), $past(op_literal)}))
		else $error("banked address wrong");
	indirect_path_a: assert property (@(posedge mclk) disable iff (rst)
		op_valid && op_indirect |=> !mem_windowed && mem_addr == $past(op_indirect_addr))
		else $error("indirect address wrong");
	// no window with extended set off
	ext_gate_a: assert property (@(posedge mclk) disable iff (rst)
		op_valid && !ext_set_en |=> !mem_windowed)
		else $error("window used with extended set off");
	valid_follow_a: assert property (@(posedge mclk) disable iff (rst)
		op_valid |=> mem_valid ##0 (mem_windowed == ($past(ext_set_en) && !$past(op_indirect)
		&& !$past(op_access_bit) && $past(op_literal) <= 8'h5F)))
		else $error("valid or window flag wrong");
	idle_valid_a: assert property (@(posedge mclk) disable iff (rst)
		!op_valid |=> !mem_valid)
		else $error("spurious valid");

	// Operand request shapes used by the checks below
	// Access Bank operand, neither indirect nor banked
	sequence acc_req_s;
		op_valid && !op_indirect && !op_access_bit;
	endsequence
	// Literal the window may take under the extended set
	sequence low_ext_s;
		ext_set_en && op_literal <= `ABWR_WIN_TOP;
	endsequence
	// Access operand that the window should take
	sequence win_req_s;
		acc_req_s ##0 low_ext_s;
	endsequence
	// Banked operand through the bank select register
	sequence bsr_req_s;
		op_valid && !op_indirect && op_access_bit;
	endsequence
	// Operand that names an indirect file operand
	sequence ind_req_s;
		op_valid && op_indirect;
	endsequence
	// Cycle with no operand offered
	sequence idle_s;
		!op_valid;
	endsequence

	window_bound_a: assert property (@(posedge mclk) disable iff (rst)
		win_req_s |=> mem_windowed
		&& ADDR_W'(mem_addr - $past(third_indirect_pointer)) <= ADDR_W'(`ABWR_WIN_TOP))
		else $error("window address outside span");

	// literal zero lands on the pointer
	window_base_a: assert property (@(posedge mclk) disable iff (rst)
		win_req_s ##0 (op_literal == 8'h00)
		|=> mem_windowed && mem_addr == $past(third_indirect_pointer))
		else $error("window base wrong");

	// extended set off keeps bank zero
	low_plain_a: assert property (@(posedge mclk) disable iff (rst)
		acc_req_s ##0 (!ext_set_en && op_literal < `ABWR_ACC_HALF)
		|=> !mem_windowed && mem_addr == ADDR_W'($past(op_literal)))
		else $error("plain access low half wrong");

	ext_banked_a: assert property (@(posedge mclk) disable iff (rst)
		bsr_req_s ##0 low_ext_s
		|=> !mem_windowed && mem_addr == ADDR_W'({$past(bank_select_register), $past(op_literal)}))
		else $error("banked address moved by window");

	ext_indirect_a: assert property (@(posedge mclk) disable iff (rst)
		ind_req_s ##0 low_ext_s
		|=> !mem_windowed && mem_addr == $past(op_indirect_addr))
		else $error("indirect address moved by window");

	// gap literals skip window with extended set
	ext_gap_a: assert property (@(posedge mclk) disable iff (rst)
		acc_req_s ##0 (ext_set_en && op_literal > `ABWR_WIN_TOP && op_literal < `ABWR_ACC_HALF)
		|=> !mem_windowed && mem_addr == ADDR_W'($past(op_literal)))
		else $error("gap literal taken by window");

	// upper half keeps normal map with extended set
	high_ext_a: assert property (@(posedge mclk) disable iff (rst)
		acc_req_s ##0 (ext_set_en && op_literal >= `ABWR_ACC_HALF)
		|=> !mem_windowed && mem_addr == ADDR_W'({`ABWR_SFR_BANK, $past(op_literal)}))
		else $error("upper access half moved by window");

	// address and flag hold while idle
	hold_addr_a: assert property (@(posedge mclk) disable iff (rst)
		idle_s |=> $stable(mem_addr) && $stable(mem_windowed))
		else $error("address moved without request");

	reset_clear_a: assert property (@(posedge mclk)
		rst |-> !mem_valid && !mem_windowed && mem_addr == '0)
		else $error("outputs not cleared in reset");

	// first edge after release stays idle
	release_idle_a: assert property (@(posedge mclk)
		$fell(rst) |-> !mem_valid && !mem_windowed && mem_addr == '0)
		else $error("outputs not idle after reset");

	// window flag only after a window request
	flag_source_a: assert property (@(posedge mclk) disable iff (rst)
		mem_valid && mem_windowed |-> $past(ext_set_en) && !$past(op_indirect)
		&& !$past(op_access_bit) && $past(op_literal) <= `ABWR_WIN_TOP)
		else $error("window flag without window request");
endmodule
`default_nettype wire

// file: verification/abwr_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module abwr_mem_model #(
	parameter int ADDR_W = 12
) (
	input wire logic mclk,
	input wire logic mem_valid,
	input wire logic [ADDR_W-1:0] mem_addr,
	output logic [ADDR_W-1:0] last_addr_ff
);
	// Keep the last address the memory was asked for
	always_ff @(posedge mclk) begin
		if (mem_valid) last_addr_ff <= mem_addr;
	end
endmodule
`default_nettype wire

// file: verification/tb_access_bank_window_remap.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin bad_count++; \
	$display("Error %s exp %h got %h", n, e, s); end end
module tb_access_bank_window_remap;
	logic mclk = 0, rst = 0, op_valid = 0, op_access_bit = 0, op_indirect = 0, ext_set_en = 0;
	logic [7:0] op_literal = 8'h00;
	logic [3:0] bank_select_register = 4'h5;
	logic [11:0] op_indirect_addr = 12'h3AB, third_indirect_pointer = 12'h000;
	logic [11:0] mem_addr, seen;
	logic mem_valid, mem_windowed;
	int bad_count = 0, checks_done = 0;
	abwr_remap dut (.mclk(mclk), .rst(rst), .op_valid(op_valid), .op_literal(op_literal),
		.op_access_bit(op_access_bit), .op_indirect(op_indirect),
		.op_indirect_addr(op_indirect_addr), .ext_set_en(ext_set_en),
		.bank_select_register(bank_select_register),
		.third_indirect_pointer(third_indirect_pointer), .mem_valid(mem_valid),
		.mem_addr(mem_addr), .mem_windowed(mem_windowed));
	abwr_mem_model m (.mclk(mclk), .mem_valid(mem_valid), .mem_addr(mem_addr),
		.last_addr_ff(seen));
	// Clock of 50 ns
	initial forever #25 mclk = ~mclk;
	// One operand, checked the cycle after it is taken
	task send(input logic [7:0] l, input logic a, i, e, input logic [11:0] p, ea,
		input logic w);
		@(posedge mclk);
		op_literal <= l;
		op_access_bit <= a;
		op_indirect <= i;
		ext_set_en <= e;
		third_indirect_pointer <= p;
		op_valid <= 1'b1;
		@(posedge mclk);
		op_valid <= 1'b0;
		#1;
		`CHK("mem_valid", 1'b1, mem_valid)
		`CHK("mem_addr", ea, mem_addr)
		`CHK("mem_windowed", w, mem_windowed)
		@(posedge mclk);
		#1;
		`CHK("mem_valid_idle", 1'b0, mem_valid)
		`CHK("model_addr", ea, seen)
		`CHK("mem_addr_held", ea, mem_addr)
	endtask
	task t_window;
		send(8'h10, 0, 0, 1, 12'h200, 12'h210, 1);
		send(8'h00, 0, 0, 1, 12'h200, 12'h200, 1);
		send(8'h5F, 0, 0, 1, 12'h200, 12'h25F, 1);
		send(8'h20, 0, 0, 1, 12'hFF0, 12'h010, 1);
		$display("window done");
	endtask
	task t_above;
		send(8'h60, 0, 0, 1, 12'h200, 12'h060, 0);
		send(8'h80, 0, 0, 1, 12'h200, 12'hF80, 0);
		$display("above done");
	endtask
	task t_other;
		send(8'h10, 1, 0, 1, 12'h200, 12'h510, 0);
		send(8'h10, 0, 1, 1, 12'h200, 12'h3AB, 0);
		send(8'h10, 0, 0, 0, 12'h200, 12'h010, 0);
		@(posedge mclk);
		bank_select_register <= 4'hA;
		send(8'h10, 1, 0, 0, 12'h200, 12'hA10, 0);
		$display("other done");
	endtask
	// Two operands on back-to-back edges
	task t_stream;
		@(posedge mclk);
		op_literal <= 8'h01;
		op_access_bit <= 1'b0;
		op_indirect <= 1'b0;
		ext_set_en <= 1'b1;
		third_indirect_pointer <= 12'h300;
		op_valid <= 1'b1;
		@(posedge mclk);
		op_literal <= 8'h70;
		#1;
		`CHK("stream_valid0", 1'b1, mem_valid)
		`CHK("stream_addr0", 12'h301, mem_addr)
		`CHK("stream_win0", 1'b1, mem_windowed)
		@(posedge mclk);
		op_valid <= 1'b0;
		#1;
		`CHK("stream_valid1", 1'b1, mem_valid)
		`CHK("stream_addr1", 12'h070, mem_addr)
		`CHK("stream_win1", 1'b0, mem_windowed)
		`CHK("stream_model0", 12'h301, seen)
		@(posedge mclk);
		#1;
		`CHK("stream_valid2", 1'b0, mem_valid)
		`CHK("stream_model1", 12'h070, seen)
		$display("stream done");
	endtask
	// Reset in mid-run clears the outputs; operands resume after it
	task t_reset;
		send(8'h30, 0, 0, 1, 12'h400, 12'h430, 1);
		@(posedge mclk);
		rst <= 1'b1;
		@(posedge mclk);
		#1;
		`CHK("rst_valid", 1'b0, mem_valid)
		`CHK("rst_addr", 12'h000, mem_addr)
		`CHK("rst_win", 1'b0, mem_windowed)
		@(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		#1;
		`CHK("release_addr", 12'h000, mem_addr)
		send(8'h30, 0, 0, 1, 12'h400, 12'h430, 1);
		$display("reset done");
	endtask
	task final_report;
		$display("checks %0d bad %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		rst <= 1'b1;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		t_window;
		t_above;
		t_other;
		t_stream;
		t_reset;
		final_report;
	end
	// Watchdog
	initial begin
		#100000;
		bad_count++;
		final_report;
	end
endmodule
`default_nettype wire
